/* File: inc/line_regs_pkg.sv */
package line_regs_pkg;

  // ==========================================================================
  // geometry
  localparam int NUM_CH = 3;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int IDX_W  = 6;
  localparam int RW_W   = 6;

  // ==========================================================================
  // register indices (byte address is four times the index)
  localparam logic [IDX_W-1:0] RX_CTRL_IDX [NUM_CH] = '{6'h05, 6'h0d, 6'h15};
  localparam logic [IDX_W-1:0] CH_CTRL_IDX [NUM_CH] = '{6'h06, 6'h0e, 6'h16};
  localparam logic [IDX_W-1:0] STATUS_IDX           = 6'h1e;

  // ==========================================================================
  // receive control fields
  localparam int RX_EQ_BIT   = 0;
  localparam int RX_MON_BIT  = 1;
  localparam int RX_MUTE_BIT = 2;

  // ==========================================================================
  // channel control fields
  localparam int CC_RAIL_BIT  = 0;
  localparam int CC_SONET_BIT = 1;
  localparam int CC_34M_BIT   = 2;
  localparam int CC_LLB_BIT   = 3;
  localparam int CC_RLB_BIT   = 4;
  localparam int CC_PT_BIT    = 5;

  // ==========================================================================
  // status fields
  localparam int ST_LOS_LSB  = 0;
  localparam int ST_MUTE_LSB = 3;

  // ==========================================================================
  // reset values and bus responses
  localparam logic [RW_W-1:0] REG_RESET   = 6'h00;
  localparam logic [1:0]      RESP_OKAY   = 2'h0;
  localparam logic [1:0]      RESP_SLVERR = 2'h2;

endpackage

/* File: inc/rx_mute_if.sv */
`timescale 1ns/1ns
interface rx_mute_if;
  logic mute_en;
  logic los;
  logic pos_in;
  logic neg_in;
  logic pos_out;
  logic neg_out;
  logic muting;

  modport ctl  (output mute_en, los, pos_in, neg_in,
                input  pos_out, neg_out, muting);
  modport chan (input  mute_en, los, pos_in, neg_in,
                output pos_out, neg_out, muting);
endinterface

/* File: hdl/rx_mute_chan.sv */
`timescale 1ns/1ns
module rx_mute_chan (
  input  wire logic  clock,
  input  wire logic  rst_n,
  rx_mute_if.chan    rx
);

  logic pos_ff;
  logic neg_ff;
  logic mute_ff;
  logic nxt_pos;
  logic nxt_neg;
  logic nxt_mute;

  // ==========================================================================
  // recovered data, forced low while loss of signal is declared and muting is enabled
  always_comb begin
    nxt_mute = rx.mute_en && rx.los;
    nxt_pos  = nxt_mute ? 1'b0 : rx.pos_in;
    nxt_neg  = nxt_mute ? 1'b0 : rx.neg_in;
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      pos_ff  <= 1'b0;
      neg_ff  <= 1'b0;
      mute_ff <= 1'b0;
    end else begin
      pos_ff  <= nxt_pos;
      neg_ff  <= nxt_neg;
      mute_ff <= nxt_mute;
    end
  end

  assign rx.pos_out = pos_ff;
  assign rx.neg_out = neg_ff;
  assign rx.muting  = mute_ff;

  // ==========================================================================
  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  AST_MUTE_LOW: assert property (
    rx.mute_en && rx.los |=> !rx.pos_out && !rx.neg_out && rx.muting)
    else $error("recovered data not muted during loss of signal");

  AST_NO_MUTE: assert property (
    rst_n && !rx.mute_en |=> rx.pos_out == $past(rx.pos_in)
                 && rx.neg_out == $past(rx.neg_in))
    else $error("recovered data altered with muting disabled");

  COV_MUTED: cover property (rx.mute_en && rx.los ##1 rx.muting);

endmodule // rx_mute_chan

/* File: hdl/line_rx_and_channel_ctrl_regs.sv */
`timescale 1ns/1ns
// Overview of operation
// - receive control bit 2 set: both recovered outputs low while loss declared
// - receive control bit 1 selects monitor mode, clear selects normal mode
// - receive control bit 0 enables the equalizer; resets to zero
// - channel control registers decode at 0x06, 0x0e and 0x16
// - channel control bits 5..0 are pattern, loopbacks, rates, rail; reset 0
// - receive control registers decode at 0x05, 0x0d and 0x15
module line_rx_and_channel_ctrl_regs (
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [7:0]  awaddr,
  input  wire logic        wvalid,
  output logic             wready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  output logic             bvalid,
  input  wire logic        bready,
  output logic [1:0]       bresp,
  input  wire logic        arvalid,
  output logic             arready,
  input  wire logic [7:0]  araddr,
  output logic             rvalid,
  input  wire logic        rready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  input  wire logic [2:0]  los_defect,
  input  wire logic [2:0]  rx_pos_in,
  input  wire logic [2:0]  rx_neg_in,
  output logic [2:0]       recovered_positive_data,
  output logic [2:0]       recovered_negative_data,
  output logic [2:0]       equalizer_enable,
  output logic [2:0]       monitor_mode,
  output logic [2:0]       pattern_test_enable,
  output logic [2:0]       remote_loopback_select,
  output logic [2:0]       local_loopback_select,
  output logic [2:0]       rate_34m_select,
  output logic [2:0]       sonet_or_t3_rate_select,
  output logic [2:0]       single_dual_rail_select
);

  localparam int N  = line_regs_pkg::NUM_CH;
  localparam int RW = line_regs_pkg::RW_W;

  // ==========================================================================
  // bus state
  logic              aw_held_ff;
  logic [7:0]        awaddr_ff;
  logic              w_held_ff;
  logic [7:0]        wbyte_ff;
  logic              wlane_ff;
  logic              bvalid_ff;
  logic [1:0]        bresp_ff;
  logic              rvalid_ff;
  logic [31:0]       rdata_ff;
  logic [1:0]        rresp_ff;
  logic              nxt_aw_held;
  logic [7:0]        nxt_awaddr;
  logic              nxt_w_held;
  logic [7:0]        nxt_wbyte;
  logic              nxt_wlane;
  logic              nxt_bvalid;
  logic [1:0]        nxt_bresp;
  logic              nxt_rvalid;
  logic [31:0]       nxt_rdata;
  logic [1:0]        nxt_rresp;

  logic              aw_hs;
  logic              w_hs;
  logic              ar_hs;
  logic              wr_fire;
  logic [7:0]        wr_addr;
  logic [7:0]        wr_byte;
  logic              wr_lane;
  logic              wr_hit;
  logic              rd_hit;
  logic [7:0]        rd_val;

  // ==========================================================================
  // register storage
  logic [RW-1:0]     rx_ctrl_ff [N];
  logic [RW-1:0]     ch_ctrl_ff [N];
  logic [RW-1:0]     nxt_rx_ctrl [N];
  logic [RW-1:0]     nxt_ch_ctrl [N];
  logic [2:0]        muting;

  // ==========================================================================
  // write channel: address and data taken in either order
  assign awready = !aw_held_ff && !bvalid_ff;
  assign wready  = !w_held_ff && !bvalid_ff;
  assign arready = !rvalid_ff;
  assign aw_hs   = awvalid && awready;
  assign w_hs    = wvalid && wready;
  assign ar_hs   = arvalid && arready;
  assign wr_addr = aw_held_ff ? awaddr_ff : awaddr;
  assign wr_byte = w_held_ff ? wbyte_ff : wdata[7:0];
  assign wr_lane = w_held_ff ? wlane_ff : wstrb[0];
  assign wr_fire = (aw_held_ff || aw_hs) && (w_held_ff || w_hs);

  always_comb begin
    wr_hit = (wr_addr[1:0] == 2'h0)
          && (wr_addr[7:2] == line_regs_pkg::STATUS_IDX);
    for (int c = 0; c < N; c++) begin
      if (wr_addr[1:0] == 2'h0
          && (wr_addr[7:2] == line_regs_pkg::RX_CTRL_IDX[c]
              || wr_addr[7:2] == line_regs_pkg::CH_CTRL_IDX[c])) begin
        wr_hit = 1'b1;
      end
    end
  end

  always_comb begin
    nxt_aw_held = wr_fire ? 1'b0 : (aw_held_ff || aw_hs);
    nxt_awaddr  = aw_hs ? awaddr : awaddr_ff;
    nxt_w_held  = wr_fire ? 1'b0 : (w_held_ff || w_hs);
    nxt_wbyte   = w_hs ? wdata[7:0] : wbyte_ff;
    nxt_wlane   = w_hs ? wstrb[0] : wlane_ff;
    nxt_bvalid  = wr_fire || (bvalid_ff && !bready);
    nxt_bresp   = bresp_ff;
    if (wr_fire) begin
      nxt_bresp = wr_hit ? line_regs_pkg::RESP_OKAY
                         : line_regs_pkg::RESP_SLVERR;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      aw_held_ff <= 1'b0;
      awaddr_ff  <= 8'h00;
      w_held_ff  <= 1'b0;
      wbyte_ff   <= 8'h00;
      wlane_ff   <= 1'b0;
      bvalid_ff  <= 1'b0;
      bresp_ff   <= 2'h0;
    end else begin
      aw_held_ff <= nxt_aw_held;
      awaddr_ff  <= nxt_awaddr;
      w_held_ff  <= nxt_w_held;
      wbyte_ff   <= nxt_wbyte;
      wlane_ff   <= nxt_wlane;
      bvalid_ff  <= nxt_bvalid;
      bresp_ff   <= nxt_bresp;
    end
  end

  assign bvalid = bvalid_ff;
  assign bresp  = bresp_ff;

  // ==========================================================================
  // per-channel registers and receive datapath
  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_ch
      rx_mute_if rxm ();

      always_comb begin
        nxt_rx_ctrl[g] = rx_ctrl_ff[g];
        nxt_ch_ctrl[g] = ch_ctrl_ff[g];
        if (wr_fire && wr_lane && wr_addr[1:0] == 2'h0) begin
          if (wr_addr[7:2] == line_regs_pkg::RX_CTRL_IDX[g]) begin
            nxt_rx_ctrl[g] = wr_byte[RW-1:0];
          end
          if (wr_addr[7:2] == line_regs_pkg::CH_CTRL_IDX[g]) begin
            nxt_ch_ctrl[g] = wr_byte[RW-1:0];
          end
        end
      end

      always_ff @(posedge clock) begin
        if (!rst_n) begin
          rx_ctrl_ff[g] <= line_regs_pkg::REG_RESET;
          ch_ctrl_ff[g] <= line_regs_pkg::REG_RESET;
        end else begin
          rx_ctrl_ff[g] <= nxt_rx_ctrl[g];
          ch_ctrl_ff[g] <= nxt_ch_ctrl[g];
        end
      end

      assign equalizer_enable[g] =
        rx_ctrl_ff[g][line_regs_pkg::RX_EQ_BIT];
      assign monitor_mode[g] =
        rx_ctrl_ff[g][line_regs_pkg::RX_MON_BIT];
      assign pattern_test_enable[g] =
        ch_ctrl_ff[g][line_regs_pkg::CC_PT_BIT];
      assign remote_loopback_select[g] =
        ch_ctrl_ff[g][line_regs_pkg::CC_RLB_BIT];
      assign local_loopback_select[g] =
        ch_ctrl_ff[g][line_regs_pkg::CC_LLB_BIT];
      assign rate_34m_select[g] =
        ch_ctrl_ff[g][line_regs_pkg::CC_34M_BIT];
      assign sonet_or_t3_rate_select[g] =
        ch_ctrl_ff[g][line_regs_pkg::CC_SONET_BIT];
      assign single_dual_rail_select[g] =
        ch_ctrl_ff[g][line_regs_pkg::CC_RAIL_BIT];

      assign rxm.mute_en = rx_ctrl_ff[g][line_regs_pkg::RX_MUTE_BIT];
      assign rxm.los     = los_defect[g];
      assign rxm.pos_in  = rx_pos_in[g];
      assign rxm.neg_in  = rx_neg_in[g];
      assign recovered_positive_data[g] = rxm.pos_out;
      assign recovered_negative_data[g] = rxm.neg_out;
      assign muting[g] = rxm.muting;

      rx_mute_chan u_mute (
        .clock (clock),
        .rst_n (rst_n),
        .rx    (rxm.chan)
      );
    end
  endgenerate

  // ==========================================================================
  // read channel
  always_comb begin
    rd_hit = 1'b0;
    rd_val = 8'h00;
    if (araddr[1:0] == 2'h0) begin
      if (araddr[7:2] == line_regs_pkg::STATUS_IDX) begin
        rd_hit = 1'b1;
        rd_val = {2'h0, muting, los_defect};
      end
      for (int c = 0; c < N; c++) begin
        if (araddr[7:2] == line_regs_pkg::RX_CTRL_IDX[c]) begin
          rd_hit = 1'b1;
          rd_val = {2'h0, rx_ctrl_ff[c]};
        end
        if (araddr[7:2] == line_regs_pkg::CH_CTRL_IDX[c]) begin
          rd_hit = 1'b1;
          rd_val = {2'h0, ch_ctrl_ff[c]};
        end
      end
    end
  end

  always_comb begin
    nxt_rvalid = ar_hs || (rvalid_ff && !rready);
    nxt_rdata  = rdata_ff;
    nxt_rresp  = rresp_ff;
    if (ar_hs) begin
      nxt_rdata = {24'h000000, rd_val};
      nxt_rresp = rd_hit ? line_regs_pkg::RESP_OKAY
                         : line_regs_pkg::RESP_SLVERR;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      rvalid_ff <= 1'b0;
      rdata_ff  <= 32'h00000000;
      rresp_ff  <= 2'h0;
    end else begin
      rvalid_ff <= nxt_rvalid;
      rdata_ff  <= nxt_rdata;
      rresp_ff  <= nxt_rresp;
    end
  end

  assign rvalid = rvalid_ff;
  assign rdata  = rdata_ff;
  assign rresp  = rresp_ff;

  // ==========================================================================
  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  AST_RESET_CLEAR: assert property (disable iff (1'b0)
    !rst_n |=> equalizer_enable == 3'h0 && pattern_test_enable == 3'h0
            && monitor_mode == 3'h0 && single_dual_rail_select == 3'h0)
    else $error("control bits not cleared by reset");

  AST_EQ_WRITE: assert property (
    wr_fire && wr_lane && wr_addr == 8'h14
    |=> equalizer_enable[0] == $past(wr_byte[0]))
    else $error("equalizer enable not written at channel 0");

  AST_MON_WRITE: assert property (
    wr_fire && wr_lane && wr_addr == 8'h34
    |=> monitor_mode[1] == $past(wr_byte[1]))
    else $error("monitor mode not written at channel 1");

  AST_CC_FIELDS: assert property (
    wr_fire && wr_lane && wr_addr == 8'h58
    |=> pattern_test_enable[2] == $past(wr_byte[5])
     && remote_loopback_select[2] == $past(wr_byte[4])
     && local_loopback_select[2] == $past(wr_byte[3])
     && rate_34m_select[2] == $past(wr_byte[2]))
    else $error("channel 2 control fields misplaced");

  AST_CC_READ: assert property (
    ar_hs && araddr == 8'h38
    |=> rvalid && rresp == 2'h0 && rdata[5:0] == {
        pattern_test_enable[1], remote_loopback_select[1],
        local_loopback_select[1], rate_34m_select[1],
        sonet_or_t3_rate_select[1], single_dual_rail_select[1]})
    else $error("channel 1 control not read back at its address");

  AST_RSVD_ZERO: assert property (
    rvalid |-> rdata[31:6] == 26'h0)
    else $error("unused bits read nonzero");

  AST_WRITE_RESP: assert property (
    wr_fire |=> bvalid ##0 (!bready)[*1] |=> bvalid)
    else $error("write response lost before acceptance");

  AST_MUTE_PATH: assert property (
    rx_ctrl_ff[0][line_regs_pkg::RX_MUTE_BIT] && los_defect[0]
    |=> !recovered_positive_data[0] && !recovered_negative_data[0])
    else $error("channel 0 outputs not muted on loss");

  COV_WRITE: cover property (wr_fire && wr_hit ##1 bvalid && bready);
  COV_READ:  cover property (ar_hs ##1 rvalid && rready);
  COV_SPLIT: cover property (w_hs && !aw_hs ##[1:4] aw_hs);

endmodule // line_rx_and_channel_ctrl_regs

/* File: dv/framer_model.sv */
`timescale 1ns/1ns
// ============================================================================
// far-side line equipment: loss flag on request, positive data changing every cycle, negative data every second cycle
module framer_model (
  input  wire logic       clock,
  input  wire logic       rst_n,
  input  wire logic [2:0] los_req,
  output logic      [2:0] los_defect,
  output logic      [2:0] rx_pos_in,
  output logic      [2:0] rx_neg_in
);
  logic [3:0] cnt_ff;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      cnt_ff <= 4'h0;
    end else begin
      cnt_ff <= cnt_ff + 4'h1;
    end
    los_defect <= los_req;
    rx_pos_in  <= cnt_ff[2:0] ^ 3'h5;
    rx_neg_in  <= ~cnt_ff[3:1];
  end
endmodule // framer_model

/* File: dv/test_line_rx_and_channel_ctrl_regs.sv */
`timescale 1ns/1ns
module test_line_rx_and_channel_ctrl_regs;
  logic        clock = 1'b0, rst_n = 1'b0;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic        arvalid = 1'b0, rready = 1'b0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0]  wstrb = 4'h0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp, r;
  logic [2:0]  los_req = 3'h0, los_defect, pos_in, neg_in, pos_o, neg_o;
  logic [2:0]  eq, mon, pt, rlb, llb, r34, rson, rail;
  logic [31:0] d;
  int          failures = 0, n_tests = 0;

  framer_model FAR (.clock(clock), .rst_n(rst_n), .los_req(los_req),
    .los_defect(los_defect), .rx_pos_in(pos_in), .rx_neg_in(neg_in));

  line_rx_and_channel_ctrl_regs DUT (.clock(clock), .rst_n(rst_n),
    .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .wvalid(wvalid),
    .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid),
    .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready),
    .araddr(araddr), .rvalid(rvalid), .rready(rready), .rdata(rdata),
    .rresp(rresp), .los_defect(los_defect), .rx_pos_in(pos_in),
    .rx_neg_in(neg_in), .recovered_positive_data(pos_o),
    .recovered_negative_data(neg_o), .equalizer_enable(eq),
    .monitor_mode(mon), .pattern_test_enable(pt),
    .remote_loopback_select(rlb), .local_loopback_select(llb),
    .rate_34m_select(r34), .sonet_or_t3_rate_select(rson),
    .single_dual_rail_select(rail));

  initial begin
    forever #10 clock = ~clock;
  end

  // ==========================================================================
  // reporting
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cmp_bits(input logic [5:0] got, input logic [5:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic hang();
    failures++;
    end_sim();
  endtask

  // ==========================================================================
  // register bus master
  task automatic axi_write(input logic [7:0] a, input logic [31:0] v,
                           output logic [1:0] resp,
                           input logic [3:0] s = 4'hf);
    int n;
    @(posedge clock);
    awvalid <= 1'b1;
    awaddr  <= a;
    wvalid  <= 1'b1;
    wdata   <= v;
    wstrb   <= s;
    bready  <= 1'b1;
    for (n = 0; n < 200; n++) begin
      @(posedge clock);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    if (n == 200) hang();
    resp = bresp;
    bready <= 1'b0;
  endtask

  task automatic axi_read(input logic [7:0] a, output logic [31:0] v,
                          output logic [1:0] resp);
    int n;
    @(posedge clock);
    arvalid <= 1'b1;
    araddr  <= a;
    rready  <= 1'b1;
    for (n = 0; n < 200; n++) begin
      @(posedge clock);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    if (n == 200) hang();
    v    = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask

  function automatic logic [7:0] rx_a(int c);
    return {line_regs_pkg::RX_CTRL_IDX[c], 2'b00};
  endfunction

  function automatic logic [7:0] cc_a(int c);
    return {line_regs_pkg::CH_CTRL_IDX[c], 2'b00};
  endfunction

  function automatic logic [5:0] cc_pins(int c);
    return {pt[c], rlb[c], llb[c], r34[c], rson[c], rail[c]};
  endfunction

  // ==========================================================================
  // scenarios
  task automatic reset_values();
    for (int c = 0; c < 3; c++) begin
      axi_read(rx_a(c), d, r);
      cmp_word(d, 32'h0);
      axi_read(cc_a(c), d, r);
      cmp_word(d, 32'h0);
      cmp_bits({cc_pins(c)}, 6'h00);
      cmp_bits({4'h0, mon[c], eq[c]}, 6'h00);
    end
  endtask

  task automatic channel_fields();
    for (int c = 0; c < 3; c++) begin
      for (int b = 0; b < 6; b++) begin
        axi_write(cc_a(c), 32'h1 << b, r);
        cmp_word({30'h0, r}, 32'h0);
        cmp_bits(cc_pins(c), 6'h01 << b);
      end
      axi_write(cc_a(c), 32'hffff_ffff, r);
      axi_read(cc_a(c), d, r);
      cmp_word(d, 32'h3f);
      cmp_bits(cc_pins(c), 6'h3f);
      axi_write(cc_a(c), 32'h0, r);
      cmp_bits(cc_pins(c), 6'h00);
    end
  endtask

  task automatic rx_fields();
    for (int c = 0; c < 3; c++) begin
      axi_write(rx_a(c), 32'h2, r);
      axi_read(rx_a(c), d, r);
      cmp_word(d, 32'h2);
      cmp_bits({4'h0, mon[c], eq[c]}, 6'h02);
    end
    for (int c = 0; c < 3; c++) begin
      axi_write(rx_a(c), 32'h1, r);
      cmp_bits({4'h0, mon[c], eq[c]}, 6'h01);
    end
  endtask

  task automatic watch_data(input logic [2:0] mute);
    logic [2:0] ep, en;
    @(negedge clock);
    for (int i = 0; i < 8; i++) begin
      ep = pos_in & ~(los_defect & mute);
      en = neg_in & ~(los_defect & mute);
      @(negedge clock);
      cmp_bits({pos_o, neg_o}, {ep, en});
    end
  endtask

  task automatic mute_on_loss();
    axi_write(rx_a(0), 32'h5, r);
    axi_write(rx_a(1), 32'h5, r);
    @(posedge clock);
    los_req <= 3'h3;
    repeat (2) @(posedge clock);
    watch_data(3'h3);
    axi_read({line_regs_pkg::STATUS_IDX, 2'b00}, d, r);
    cmp_word(d, (32'h3 << line_regs_pkg::ST_MUTE_LSB)
              | (32'h3 << line_regs_pkg::ST_LOS_LSB));
    los_req <= 3'h0;
    watch_data(3'h3);
    axi_write(rx_a(1), 32'h1, r);
    los_req <= 3'h2;
    watch_data(3'h1);
    @(posedge clock);
    los_req <= 3'h0;
  endtask

  task automatic bad_access();
    axi_write(8'h1c, 32'h3f, r);
    cmp_word({30'h0, r}, {30'h0, line_regs_pkg::RESP_SLVERR});
    axi_read(8'h1c, d, r);
    cmp_word(d, 32'h0);
    cmp_word({30'h0, r}, {30'h0, line_regs_pkg::RESP_SLVERR});
    axi_write(8'h1a, 32'h3f, r);
    cmp_word({30'h0, r}, {30'h0, line_regs_pkg::RESP_SLVERR});
    axi_write(cc_a(0), 32'h3f, r, 4'he);
    cmp_word({30'h0, r}, {30'h0, line_regs_pkg::RESP_OKAY});
    axi_read(cc_a(0), d, r);
    cmp_word(d, 32'h0);
  endtask

  // ==========================================================================
  // main sequence
  initial begin
    repeat (16) @(posedge clock);
    rst_n <= 1'b1;
    reset_values();
    channel_fields();
    rx_fields();
    mute_on_loss();
    bad_access();
    end_sim();
  end
endmodule // test_line_rx_and_channel_ctrl_regs
